// ### hdl/isc_pkg.sv
// Package: constants and state type of the supply-control register block.
//
// Contract
// - write is address, sub-address, one data byte
// - receiver acknowledges low after every 8 bits
// - no auto-increment, one data byte per write
// - read returns voltage selects then fault flags
// - enable register bits 7:3, low bits zero
// - bits 7:6 of 01h select illumination voltage
// - 01h disc, sound and main rail selects
// - select field ignored while its output enabled
// - 02h ignition and undervoltage threshold selects
// - 02h bit3 adds thermal warning to alarm
// - status byte flags bits 7:2, low zero
// - supply power-up resets logic into standby
// - overcurrent flag when any switched output limits
// - low rail past delay drives reset, clears
// - rail recovers, release pin, delay internal reset
// - undervoltage sets flag, drives battery alarm low
// - overvoltage sets flag, drives battery alarm low
// - shutdown flag clears enables, alarm low
// - ignition low sets flag, alarm pin low
// - thermal flag follows die temperature condition
`default_nettype none
package isc_pkg;
    localparam logic [6:0] DEV_ADDR = 7'h08;
    localparam logic [7:0] REG_PWR_EN = 8'h00;
    localparam logic [7:0] REG_VSEL = 8'h01;
    localparam logic [7:0] REG_MON = 8'h02;
    localparam logic [7:0] PWR_EN_RST = 8'h00;
    localparam logic [7:0] VSEL_RST = 8'h00;
    localparam logic [7:0] MON_RST = 8'h00;
    localparam logic [7:0] PWR_EN_MASK = 8'hF8;
    localparam logic [7:0] MON_MASK = 8'hFB;
    // enable bit positions
    localparam int PE_ILLUM = 7;
    localparam int PE_DISC = 6;
    localparam int PE_SOUND = 5;
    localparam int PE_MAIN = 4;
    localparam int PE_HS = 3;
    // select field low bits
    localparam int VS_ILLUM = 6;
    localparam int VS_DISC = 4;
    localparam int VS_SOUND = 2;
    localparam int VS_MAIN = 1;
    localparam int MC_IGN = 6;
    localparam int MC_UNDER = 4;
    localparam int MC_MODE = 3;
    // flag positions
    localparam int FL_IGN = 7;
    localparam int FL_UNDERVOLT = 6;
    localparam int FL_OVERVOLT = 5;
    localparam int FL_SHUTDOWN = 4;
    localparam int FL_THERMAL = 3;
    localparam int FL_OVERCUR = 2;
    localparam int OUT_N = 5;
    localparam int SYNC_W = 14;
    // timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int ASSERT_DELAY_NS = 25000;
    localparam int RELEASE_DELAY_NS = 100000;
    localparam int ASSERT_CYC =
        (ASSERT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RELEASE_CYC =
        (RELEASE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [11:0] ASSERT_LAST = 12'(ASSERT_CYC - 1);
    localparam logic [11:0] RELEASE_LAST = 12'(RELEASE_CYC - 1);
    typedef enum logic [3:0] {
        S_IDLE, S_ADDR, S_ADDR_ACK, S_SUB, S_SUB_ACK,
        S_DATA, S_DATA_ACK, S_TX, S_TX_ACK, S_WAIT
    } isc_bus_st_t;
endpackage : isc_pkg
`default_nettype wire

// ### hdl/isc_regs.sv
// Two-wire slave with control registers and fault status.
`default_nettype none
module isc_regs (
    input wire logic clk,
    input wire logic rst,
    input wire logic scl,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    input wire logic resetOutNIn,
    output logic resetOutNOut,
    output logic resetOutNOe,
    input wire logic railLow,
    input wire logic ignLowCmp,
    input wire logic undervoltDetector,
    input wire logic overvoltDetector,
    input wire logic shutdownCmp,
    input wire logic thermalCmp,
    input wire logic [isc_pkg::OUT_N-1:0] curLimit,
    output logic illumOutOn,
    output logic discOutOn,
    output logic soundOutOn,
    output logic mainRailOn,
    output logic hsSwitchOn,
    output logic [1:0] illumVoltSel,
    output logic [1:0] discVoltSel,
    output logic [1:0] soundVoltSel,
    output logic mainRailVoltSel,
    output logic [1:0] ignitionThreshSel,
    output logic [1:0] undervoltThreshSel,
    output logic battAlarmMode,
    output logic battAlarmN,
    output logic ignitionAlarmN
);
    import isc_pkg::*;

    typedef struct packed {
        isc_bus_st_t st;
        logic [3:0] bitCnt;
        logic [7:0] rxSh;
        logic [7:0] subAddr;
        logic isRead;
        logic byteIdx;
        logic mAck;
        logic [15:0] txSh;
        logic sdaOe;
        logic sdaOut;
        logic sclPrev;
        logic sdaPrev;
        logic wrDone;
        logic [7:0] pwrEn;
        logic [7:0] vsel;
        logic [7:0] monCfg;
        logic [7:0] flags;
        logic battAlarmN;
        logic ignAlarmN;
    } isc_top_state_t;

    isc_top_state_t q;
    isc_top_state_t n;

    logic [SYNC_W-1:0] syncIn;
    logic [SYNC_W-1:0] syncOut;
    logic sclS;
    logic sdaS;
    logic railLowS;
    logic rstPinS;
    logic ignS;
    logic underS;
    logic overS;
    logic shutS;
    logic thermS;
    logic [OUT_N-1:0] curS;
    logic intRst;
    logic rstAll;
    logic sclRise;
    logic sclFall;
    logic startC;
    logic stopC;
    logic [7:0] flagsNext;

    // ------------------------------------------------------------
    // input synchronisation and reset sequencing
    // ------------------------------------------------------------
    assign syncIn = {scl, sdaIn, railLow, resetOutNIn, ignLowCmp,
                     undervoltDetector, overvoltDetector, shutdownCmp,
                     thermalCmp, curLimit};

    isc_sync #(
        .W(SYNC_W)
    ) u_sync (
        .clk(clk),
        .rst(rst),
        .din(syncIn),
        .dout(syncOut)
    );

    assign {sclS, sdaS, railLowS, rstPinS, ignS, underS, overS, shutS,
            thermS, curS} = syncOut;

    isc_rst_delay u_rst_delay (
        .clk(clk),
        .rst(rst),
        .railLow(railLowS),
        .pinIn(rstPinS),
        .pinOut(resetOutNOut),
        .pinOe(resetOutNOe),
        .intRst(intRst)
    );

    assign rstAll = rst | intRst;

    // ------------------------------------------------------------
    // bus conditions
    // ------------------------------------------------------------
    assign sclRise = sclS & ~q.sclPrev;
    assign sclFall = ~sclS & q.sclPrev;
    assign startC = q.sclPrev & sclS & q.sdaPrev & ~sdaS;
    assign stopC = q.sclPrev & sclS & ~q.sdaPrev & sdaS;

    // flags track the comparators live; nothing to clear
    assign flagsNext = {ignS, underS, overS, shutS, thermS,
                        |curS, 2'b00};

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        n = q;
        n.sclPrev = sclS;
        n.sdaPrev = sdaS;
        n.sdaOut = 1'b0;
        n.wrDone = 1'b0;
        n.flags = flagsNext;
        n.ignAlarmN = ~flagsNext[FL_IGN];
        n.battAlarmN = ~(flagsNext[FL_UNDERVOLT]
                       | flagsNext[FL_OVERVOLT]
                       | flagsNext[FL_SHUTDOWN]
                       | (q.monCfg[MC_MODE]
                          & flagsNext[FL_THERMAL]));
        if (startC) begin
            n.st = S_ADDR;
            n.bitCnt = 4'h0;
            n.sdaOe = 1'b0;
        end else if (stopC) begin
            n.st = S_IDLE;
            n.sdaOe = 1'b0;
        end else if (sclRise) begin
            case (q.st)
                S_ADDR, S_SUB, S_DATA: begin
                    // msb arrives first
                    n.rxSh = {q.rxSh[6:0], sdaS};
                    n.bitCnt = q.bitCnt + 4'h1;
                end
                S_TX: begin
                    n.bitCnt = q.bitCnt + 4'h1;
                end
                S_TX_ACK: begin
                    n.mAck = ~sdaS;
                end
                default: begin
                end
            endcase
        end else if (sclFall) begin
            case (q.st)
                S_ADDR: begin
                    if (q.bitCnt == 4'h8) begin
                        if (q.rxSh[7:1] == DEV_ADDR) begin
                            n.isRead = q.rxSh[0];
                            n.sdaOe = 1'b1;
                            n.st = S_ADDR_ACK;
                        end else begin
                            n.st = S_WAIT;
                        end
                    end
                end
                S_ADDR_ACK: begin
                    n.bitCnt = 4'h0;
                    if (q.isRead) begin
                        // no sub-address in a read
                        n.txSh = {q.vsel, q.flags};
                        n.byteIdx = 1'b0;
                        n.sdaOe = ~q.vsel[7];
                        n.st = S_TX;
                    end else begin
                        n.sdaOe = 1'b0;
                        n.st = S_SUB;
                    end
                end
                S_SUB: begin
                    if (q.bitCnt == 4'h8) begin
                        n.subAddr = q.rxSh;
                        n.sdaOe = 1'b1;
                        n.st = S_SUB_ACK;
                    end
                end
                S_SUB_ACK: begin
                    n.sdaOe = 1'b0;
                    n.bitCnt = 4'h0;
                    n.st = S_DATA;
                end
                S_DATA: begin
                    if (q.bitCnt == 4'h8) begin
                        n.sdaOe = 1'b1;
                        n.wrDone = 1'b1;
                        n.st = S_DATA_ACK;
                        case (q.subAddr)
                            REG_PWR_EN: begin
                                n.pwrEn = q.rxSh & PWR_EN_MASK;
                            end
                            REG_VSEL: begin
                                // a field is frozen while its output is on
                                if (!q.pwrEn[PE_ILLUM]) begin
                                    n.vsel[VS_ILLUM+:2] =
                                        q.rxSh[VS_ILLUM+:2];
                                end
                                if (!q.pwrEn[PE_DISC]) begin
                                    n.vsel[VS_DISC+:2] =
                                        q.rxSh[VS_DISC+:2];
                                end
                                if (!q.pwrEn[PE_SOUND]) begin
                                    n.vsel[VS_SOUND+:2] =
                                        q.rxSh[VS_SOUND+:2];
                                end
                                if (!q.pwrEn[PE_MAIN]) begin
                                    n.vsel[VS_MAIN] =
                                        q.rxSh[VS_MAIN];
                                end
                            end
                            REG_MON: begin
                                n.monCfg = q.rxSh & MON_MASK;
                            end
                            default: begin
                                // acknowledged, nothing stored
                            end
                        endcase
                    end
                end
                S_DATA_ACK: begin
                    // further bytes get no acknowledge and are dropped
                    n.sdaOe = 1'b0;
                    n.st = S_WAIT;
                end
                S_TX: begin
                    if (q.bitCnt == 4'h8) begin
                        n.sdaOe = 1'b0;
                        n.st = S_TX_ACK;
                    end else begin
                        n.txSh = {q.txSh[14:0], 1'b0};
                        n.sdaOe = ~q.txSh[14];
                    end
                end
                S_TX_ACK: begin
                    if (q.mAck && !q.byteIdx) begin
                        n.txSh = {q.txSh[14:0], 1'b0};
                        n.sdaOe = ~q.txSh[14];
                        n.byteIdx = 1'b1;
                        n.bitCnt = 4'h0;
                        n.st = S_TX;
                    end else begin
                        n.sdaOe = 1'b0;
                        n.st = S_WAIT;
                    end
                end
                default: begin
                end
            endcase
        end
        // protection shutdown beats any write in the same cycle
        if (flagsNext[FL_SHUTDOWN]) begin
            n.pwrEn = PWR_EN_RST;
        end
        if (rstAll) begin
            n = '0;
            n.st = S_IDLE;
            n.pwrEn = PWR_EN_RST;
            n.vsel = VSEL_RST;
            n.monCfg = MON_RST;
            n.battAlarmN = 1'b1;
            n.ignAlarmN = 1'b1;
            n.sclPrev = sclS;
            n.sdaPrev = sdaS;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q <= '0;
            q.st <= S_IDLE;
            q.battAlarmN <= 1'b1;
            q.ignAlarmN <= 1'b1;
            q.sclPrev <= 1'b1;
            q.sdaPrev <= 1'b1;
        end else begin
            q <= n;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign sdaOut = q.sdaOut;
    assign sdaOe = q.sdaOe;
    assign illumOutOn = q.pwrEn[PE_ILLUM];
    assign discOutOn = q.pwrEn[PE_DISC];
    assign soundOutOn = q.pwrEn[PE_SOUND];
    assign mainRailOn = q.pwrEn[PE_MAIN];
    assign hsSwitchOn = q.pwrEn[PE_HS];
    assign illumVoltSel = q.vsel[VS_ILLUM+:2];
    assign discVoltSel = q.vsel[VS_DISC+:2];
    assign soundVoltSel = q.vsel[VS_SOUND+:2];
    assign mainRailVoltSel = q.vsel[VS_MAIN];
    assign ignitionThreshSel = q.monCfg[MC_IGN+:2];
    assign undervoltThreshSel = q.monCfg[MC_UNDER+:2];
    assign battAlarmMode = q.monCfg[MC_MODE];
    assign battAlarmN = q.battAlarmN;
    assign ignitionAlarmN = q.ignAlarmN;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_sub_done;
        q.st == S_SUB && q.bitCnt == 4'h8 && sclFall;
    endsequence

    property p_sub_ack;
        @(posedge clk) disable iff (rstAll)
            s_sub_done |=> q.sdaOe && q.st == S_SUB_ACK;
    endproperty
    a_sub_ack: assert property (p_sub_ack)
        else $error("sub-address byte not acknowledged");

    property p_pwr_low;
        @(posedge clk) disable iff (rstAll) q.pwrEn[2:0] == 3'b000;
    endproperty
    a_pwr_low: assert property (p_pwr_low)
        else $error("enable register low bits set");

    property p_vsel_lock;
        @(posedge clk) disable iff (rstAll)
            ($past(q.pwrEn[PE_ILLUM]) && !$past(rstAll))
            |-> q.vsel[7:6] == $past(q.vsel[7:6]);
    endproperty
    a_vsel_lock: assert property (p_vsel_lock)
        else $error("illumination select changed while enabled");

    property p_mon_bit2;
        @(posedge clk) disable iff (rstAll) q.monCfg[2] == 1'b0;
    endproperty
    a_mon_bit2: assert property (p_mon_bit2)
        else $error("monitor config bit 2 set");

    property p_flag_low;
        @(posedge clk) disable iff (rstAll) q.flags[1:0] == 2'b00;
    endproperty
    a_flag_low: assert property (p_flag_low)
        else $error("status low bits set");

    property p_overcur;
        @(posedge clk) disable iff (rstAll)
            !$past(rstAll) |-> q.flags[FL_OVERCUR] == $past(|curS);
    endproperty
    a_overcur: assert property (p_overcur)
        else $error("overcurrent flag does not follow limits");

    property p_shutdown;
        @(posedge clk) disable iff (rstAll)
            q.flags[FL_SHUTDOWN] |-> q.pwrEn == PWR_EN_RST && !q.battAlarmN;
    endproperty
    a_shutdown: assert property (p_shutdown)
        else $error("enables kept during protection shutdown");

    property p_batt_alarm;
        @(posedge clk) disable iff (rstAll)
            (q.flags[FL_UNDERVOLT] || q.flags[FL_OVERVOLT]) |-> !q.battAlarmN;
    endproperty
    a_batt_alarm: assert property (p_batt_alarm)
        else $error("battery alarm not low on supply fault");

    property p_ign_alarm;
        @(posedge clk) disable iff (rstAll) q.flags[FL_IGN] != q.ignAlarmN;
    endproperty
    a_ign_alarm: assert property (p_ign_alarm)
        else $error("ignition alarm disagrees with flag");

    property p_unmapped;
        @(posedge clk) disable iff (rstAll)
            (q.wrDone && q.subAddr > REG_MON && !$past(rstAll))
            |-> q.vsel == $past(q.vsel) && q.monCfg == $past(q.monCfg);
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped write changed a register");
endmodule : isc_regs
`default_nettype wire

// ### hdl/isc_rst_delay.sv
// Reset pin sequencing with assert and release delays.
`default_nettype none
module isc_rst_delay (
    input wire logic clk,
    input wire logic rst,
    input wire logic railLow,
    input wire logic pinIn,
    output logic pinOut,
    output logic pinOe,
    output logic intRst
);
    import isc_pkg::*;

    typedef struct packed {
        logic pinLow;
        logic intRst;
        logic pinOut;
        logic [11:0] cnt;
    } isc_rd_state_t;

    isc_rd_state_t q;
    isc_rd_state_t n;

    always_comb begin
        n = q;
        n.pinOut = 1'b0;
        if (q.pinLow) begin
            n.cnt = '0;
            if (!railLow) begin
                n.pinLow = 1'b0;
            end
        end else if (railLow) begin
            if (q.cnt == ASSERT_LAST) begin
                n.pinLow = 1'b1;
                n.intRst = 1'b1;
                n.cnt = '0;
            end else begin
                n.cnt = q.cnt + 12'h001;
            end
        end else if (q.intRst) begin
            // a capacitor on the pin stretches the internal reset
            if (!pinIn) begin
                n.cnt = '0;
            end else if (q.cnt == RELEASE_LAST) begin
                n.intRst = 1'b0;
                n.cnt = '0;
            end else begin
                n.cnt = q.cnt + 12'h001;
            end
        end else begin
            n.cnt = '0;
            if (!pinIn) begin
                n.intRst = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign pinOut = q.pinOut;
    assign pinOe = q.pinLow;
    assign intRst = q.intRst;

    sequence s_pin_release;
        $fell(q.pinLow);
    endsequence

    property p_pin_hold;
        @(posedge clk) disable iff (rst) q.pinLow |-> q.intRst;
    endproperty
    a_pin_hold: assert property (p_pin_hold)
        else $error("internal reset not held with pin low");

    property p_release_delay;
        @(posedge clk) disable iff (rst)
            s_pin_release |-> q.intRst [*8];
    endproperty
    a_release_delay: assert property (p_release_delay)
        else $error("internal reset ended before release delay");
endmodule : isc_rst_delay
`default_nettype wire

// ### hdl/isc_sync.sv
// Two-stage synchroniser for inputs from outside the clock domain.
`default_nettype none
module isc_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } isc_sync_state_t;

    isc_sync_state_t q;
    isc_sync_state_t n;

    always_comb begin
        n.s1 = din;
        n.s2 = q.s1;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            // preset to the pin level so no false edge follows reset
            q <= {din, din};
        end else begin
            q <= n;
        end
    end

    assign dout = q.s2;
endmodule : isc_sync
`default_nettype wire

// ### tb/isc_host.sv
// Host controller model driving the two-wire bus.
`default_nettype none
module isc_host (
    input wire logic clk,
    input wire logic sda,
    output logic scl,
    output logic sdaLow
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] rdWord;
    event done;
    initial begin
        scl = 1'b1;
        sdaLow = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick
    // ----------------------------------------
    // bit level, 320 ns per bit
    // ----------------------------------------
    task automatic bitx(input logic b, output logic r);
        tick(1);
        sdaLow = !b;
        tick(3);
        scl = 1'b1;
        tick(2);
        r = sda;
        tick(2);
        scl = 1'b0;
    endtask : bitx
    // msb first, then ninth bit; a=1 releases for ack
    task automatic xfer(input logic [7:0] d, input logic a,
        output logic [8:0] r);
        for (int i = 8; i >= 0; i--) bitx(i > 0 ? d[i-1] : a, r[i]);
    endtask : xfer
    task automatic start();
        tick(1);
        sdaLow = 1'b0;
        scl = 1'b1;
        tick(4);
        sdaLow = 1'b1;
        tick(4);
        scl = 1'b0;
    endtask : start
    // clock stands high after stop
    task automatic stop();
        tick(1);
        sdaLow = 1'b1;
        tick(3);
        scl = 1'b1;
        tick(4);
        sdaLow = 1'b0;
        tick(4);
    endtask : stop
    // one data byte then stop
    task automatic wr(input logic [7:0] a, s, d);
        logic [8:0] r0, r1, r2;
        start();
        xfer(a, 1'b1, r0);
        xfer(s, 1'b1, r1);
        xfer(d, 1'b1, r2);
        stop();
        rdWord = {13'h0, r0[0], r1[0], r2[0]};
        ->done;
    endtask : wr
    // no sub-address; ack first byte, nack second
    task automatic rd();
        logic [8:0] r0, r1, r2;
        start();
        xfer({isc_pkg::DEV_ADDR, 1'b1}, 1'b1, r0);
        xfer(8'hFF, 1'b0, r1);
        xfer(8'hFF, 1'b1, r2);
        stop();
        rdWord = {r1[8:1], r2[8:1]};
        ->done;
    endtask : rd
endmodule : isc_host
`default_nettype wire

// ### tb/tb.sv
// Self-checking bench of the supply-control register block.
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import isc_pkg::*;
`define CHK(o, e) begin comparisons++; if ((o) !== (e)) begin \
    num_errors++; $display("mismatch at %0t got %h expected %h", \
    $time, o, e); end end
    logic clk = 1'b0, rst, scl, sdaLow, sdaOut, sdaOe, rOut, rOe, railLow;
    logic ign, uv, ov, shut, therm, ill, dis, snd, mr, hs, mvs, mode;
    logic bA, iA, re;
    logic [1:0] ivs, dvs, svs, ith, uth;
    logic [4:0] curLimit;
    logic [7:0] pe, vs, mc;
    logic [5:0] f;
    logic [19:0] e1, e2, expQ[$], pinQ[$];
    int num_errors = 0, comparisons = 0;
    event snap;
    wire logic sda = (sdaOe ? sdaOut : 1'b1) & !sdaLow;
    wire logic rPin = rOe ? rOut : 1'b1;
    wire logic [19:0] pv = {!rPin, ill, dis, snd, mr, hs, ivs, dvs, svs,
        mvs, ith, uth, mode, bA, iA};
    always #20 clk = ~clk;
    isc_host host (.clk(clk), .sda(sda), .scl(scl), .sdaLow(sdaLow));
    isc_regs dut (.clk(clk), .rst(rst), .scl(scl), .sdaIn(sda),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .resetOutNIn(rPin),
        .resetOutNOut(rOut), .resetOutNOe(rOe), .railLow(railLow),
        .ignLowCmp(ign), .undervoltDetector(uv), .overvoltDetector(ov),
        .shutdownCmp(shut), .thermalCmp(therm), .curLimit(curLimit),
        .illumOutOn(ill), .discOutOn(dis), .soundOutOn(snd),
        .mainRailOn(mr), .hsSwitchOn(hs), .illumVoltSel(ivs),
        .discVoltSel(dvs), .soundVoltSel(svs), .mainRailVoltSel(mvs),
        .ignitionThreshSel(ith), .undervoltThreshSel(uth),
        .battAlarmMode(mode), .battAlarmN(bA), .ignitionAlarmN(iA));
    // ----------------------------------------
    // result monitors
    // ----------------------------------------
    always @(host.done) begin
        e1 = expQ.pop_front();
        `CHK(20'(host.rdWord), e1)
    end
    always @(snap) begin
        e2 = pinQ.pop_front();
        `CHK(pv, e2)
    end
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : summarize
    task automatic chk();
        pinQ.push_back({re, pe[7:3], vs[7:1], mc[7:3],
            !(f[4] | f[3] | f[2] | (mc[3] & f[1])), !f[5]});
        ->snap;
    endtask : chk
    task automatic drive();
        ign = f[5];
        uv = f[4];
        ov = f[3];
        shut = f[2];
        therm = f[1];
        curLimit = f[0] ? 5'(1 << ($urandom % 5)) : 5'h0;
    endtask : drive
    task automatic rd();
        expQ.push_back({4'h0, vs, f, 2'b00});
        host.rd();
    endtask : rd
    task automatic wr(input logic [7:0] s, d);
        logic [7:0] m;
        m = {{2{!pe[7]}}, {2{!pe[6]}}, {2{!pe[5]}}, !pe[4], 1'b0};
        expQ.push_back(20'h0);
        host.wr({DEV_ADDR, 1'b0}, s, d);
        if (s == REG_PWR_EN) pe = d & PWR_EN_MASK;
        if (s == REG_VSEL) vs = (vs & ~m) | (d & m);
        if (s == REG_MON) mc = d & MON_MASK;
        chk();
    endtask : wr
    initial begin
        #1500000;
        num_errors++;
        summarize();
    end
    initial begin
        rst = 1'b1;
        railLow = 1'b0;
        re = 1'b0;
        {f, pe, vs, mc} = '0;
        void'($urandom(32'h0311faf9));
        drive();
        host.tick(20);
        rst = 1'b0;
        host.tick(4);
        chk();
        rd();
        $display("test reset done");
        for (int k = 0; k < 4; k++) begin
            wr(REG_VSEL, {4{2'(k)}});
            wr(REG_MON, {2'(k), 2'(k), 1'(k), 3'b100});
            rd();
        end
        $display("test selects done");
        for (int k = 0; k < 4; k++) begin
            wr(REG_PWR_EN, 8'($urandom));
            wr(REG_VSEL, 8'($urandom));
            rd();
            wr(8'h03, 8'($urandom));
        end
        expQ.push_back(20'h7);
        host.wr(8'h12, REG_PWR_EN, 8'hF8);
        chk();
        $display("test lock done");
        for (int m = 0; m < 2; m++) begin
            wr(REG_MON, {2'(m), 2'(m), 1'(m), 3'b000});
            wr(REG_PWR_EN, 8'hF8);
            // one random mix first, then each flag alone, then all clear
            for (int i = 0; i < 8; i++) begin
                f = (i == 0) ? 6'($urandom) : 6'(1 << (i - 1));
                drive();
                if (f[2]) pe = 8'h00;
                host.tick(5);
                chk();
                rd();
            end
        end
        $display("test flags done");
        railLow = 1'b1;
        host.tick(600);
        chk();
        host.tick(100);
        {re, pe, vs, mc} = {1'b1, 24'h0};
        chk();
        railLow = 1'b0;
        re = 1'b0;
        host.tick(100);
        expQ.push_back(20'hFFFF);
        host.rd();
        host.tick(2500);
        chk();
        rd();
        $display("test rail done");
        host.tick(10);
        summarize();
    end
endmodule : tb
`default_nettype wire
